// ===== bench/tap_ctrl_model.sv
// Purpose: scan controller model
// Assumes: 8 MCLK per test clock
// Notes: clock low between frames
`timescale 1ns/10ps
module tap_ctrl_model (
  input wire clk,
  input wire line,
  output reg tck = 0,
  output reg tms = 1,
  output reg tdi = 1,
  output reg trst_n = 0
);
  task set_reset(input r);
    @(posedge clk) trst_n <= r;
  endtask
  task step(input m, input t, output o);
    tms <= m;
    tdi <= t;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk) o = line;
    @(posedge clk) tck <= 1'b0;
  endtask
endmodule // tap_ctrl_model

// ===== bench/tap_port_chk.sv
// Purpose: port checks
// Assumes: one clock
// Notes: bound below
`timescale 1ns/10ps
module tap_port_chk (
  input wire MCLK,
  input wire RSTN,
  input wire TEST_PORT_CLOCK,
  input wire TEST_PORT_RESET_N,
  input wire DIGITAL_PINS_ENABLE,
  input wire TEST_SERIAL_OUT,
  input wire TEST_SERIAL_OUT_OE,
  input wire DIGITAL_PINS_FLOAT,
  input wire TEST_MODE_ACTIVE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  sequence s_low;
    (!TEST_PORT_RESET_N)[*8];
  endsequence
  sequence s_up;
    $rose(TEST_PORT_RESET_N) ##1 TEST_PORT_RESET_N[*6];
  endsequence
  chk_float_on: assert property (s_low ##0 !DIGITAL_PINS_ENABLE[*8] |-> DIGITAL_PINS_FLOAT)
    else $error("no float");
  chk_float_off: assert property (DIGITAL_PINS_ENABLE[*8] |-> !DIGITAL_PINS_FLOAT)
    else $error("float");
  chk_mode_drop: assert property (s_low |-> !TEST_MODE_ACTIVE)
    else $error("mode held");
  chk_port_reset: assert property (s_low |-> !TEST_SERIAL_OUT_OE)
    else $error("oe in reset");
  chk_id_mode: assert property (s_up |-> TEST_MODE_ACTIVE)
    else $error("no mode");
  chk_out_fall: assert property ($changed(TEST_SERIAL_OUT) && TEST_MODE_ACTIVE
    |-> !$past(TEST_PORT_CLOCK, 2)) else $error("out moved");
  chk_oe_fall: assert property ($changed(TEST_SERIAL_OUT_OE) && TEST_MODE_ACTIVE
    |-> !$past(TEST_PORT_CLOCK, 2)) else $error("oe moved");
  chk_high_hold: assert property ((TEST_PORT_CLOCK && TEST_PORT_RESET_N)[*4]
    |-> $stable(TEST_SERIAL_OUT)) else $error("out on rise");
endmodule // tap_port_chk
bind tap_port tap_port_chk u_chk (.MCLK, .RSTN, .TEST_PORT_CLOCK, .TEST_PORT_RESET_N,
  .DIGITAL_PINS_ENABLE, .TEST_SERIAL_OUT, .TEST_SERIAL_OUT_OE, .DIGITAL_PINS_FLOAT,
  .TEST_MODE_ACTIVE);

// ===== bench/tap_port_tb_top.sv
// Purpose: bench for tap_port
// Assumes: far model drives port
// Notes: fixed seed
`timescale 1ns/10ps
module tap_port_tb_top;
  reg clk = 0, rstn = 0, en = 0, b;
  wire tck, tms, tdi, trn, tdo, oe, flt, act;
  integer errors = 0, checked = 0, seed = 47064, i;
  reg [63:0] v;
  reg [31:0] d;
  localparam [31:0] ID = 32'h5a3c0f01; // arbitrary
  always #12.5 clk = ~clk;
  tap_port #(.ID_CODE(ID)) DUT (.MCLK(clk), .RSTN(rstn), .TEST_PORT_CLOCK(tck),
    .TEST_PORT_RESET_N(trn), .TEST_MODE_SELECT(tms), .TEST_SERIAL_IN(tdi),
    .DIGITAL_PINS_ENABLE(en), .TEST_SERIAL_OUT(tdo), .TEST_SERIAL_OUT_OE(oe),
    .DIGITAL_PINS_FLOAT(flt), .TEST_MODE_ACTIVE(act));
  tap_ctrl_model far (.clk(clk), .line(oe ? tdo : ~tdo), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trn));
  function [2:0] pins(input e, input r);
    pins = {~e & ~r, r, 1'b0};
  endfunction
  task check(input [31:0] s, input [31:0] x);
    checked = checked + 1;
    if (s !== x) begin
      errors = errors + 1;
      $display("unexpected at %0t: %h", $time, s);
    end
  endtask
  task conclude;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // enter, shift 64 bits, update
  task scan;
    d = $random(seed);
    for (i = 0; i < 68; i = i + 1) far.step(i == 1 || i == 67, d[(i + 28) % 32], v[(i + 60) % 64]);
    far.step(1'b1, 1'b1, b);
    far.step(1'b0, 1'b1, b);
    check(v[31:0], ID);
    check(v[63:32], d);
    check(oe, 1'b0);
    $display("scan done");
  endtask
  // load bypass through the instruction path, then random bits pass one stage late
  task bscan;
    d = $random(seed);
    for (i = 0; i < 10; i = i + 1) far.step(i < 2 || i == 7 || i == 8, 1'b1, v[i]);
    check(v[7:4], 4'h1);
    for (i = 0; i < 37; i = i + 1)
      far.step(i == 0 || i == 34 || i == 35, d[(i + 29) % 32], v[(i + 60) % 64]);
    check(v[30:0], d[30:0]);
    check(v[63], 1'b0);
    check(oe, 1'b0);
    $display("bypass done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 2; i = i + 1) begin
      en <= i[0];
      repeat (8) @(posedge clk);
      check({flt, act, oe}, pins(en, 1'b0));
    end
    far.set_reset(1'b1);
    repeat (8) @(posedge clk);
    check({flt, act, oe}, pins(en, 1'b1));
    $display("pins done");
    scan;
    for (i = 0; i < 5; i = i + 1) far.step(1'b1, 1'b0, b);
    scan;
    bscan;
    for (i = 0; i < 5; i = i + 1) far.step(i == 0, 1'b0, b);
    check(oe, 1'b1);
    far.set_reset(1'b0);
    en <= 1'b0;
    far.step(1'b0, 1'b0, b);
    check({flt, act, oe}, pins(1'b0, 1'b0));
    $display("reset done");
    conclude;
  end
  initial begin
    #100000;
    errors = errors + 1;
    conclude;
  end
endmodule // tap_port_tb_top

// ===== design/tap_defs.vh
// Purpose: constants for the boundary-scan test port
// Assumes: instruction register of TAP_IR_BITS bits
// Notes: Operation list below
//
// Operation
// - Low test reset forces the port controller to reset, clock or not.
// - Rising test reset selects identification code instruction.
// - Low test reset drops test mode; pins work normally while digital enable is high.
// - Mode select sampled on rising test clock steps the state sequence.
// - Serial input bits captured on rising test clock.
// - Serial output changes only on falling test clock.
// - Digital enable low with test reset low floats digital pins.
// - Digital enable high leaves digital pins operating normally.
`ifndef TAP_DEFS_VH
`define TAP_DEFS_VH
`define TAP_IR_BITS 4
`define TAP_IR_IDCODE 4'h1
`define TAP_IR_BYPASS 4'hf
`define TAP_IR_CAPTURE 4'h1
`define TAP_ID_RESET 32'h00000001
`define TAP_ID_BITS 32
`define TAP_WARM_BITS 3
`define TAP_SY_BITS 5
`define TAP_SY_DEN 4
`define TAP_SY_TRST 3
`define TAP_SY_TMS 2
`define TAP_SY_TDI 1
`define TAP_SY_TCK 0
`endif

// ===== design/tap_port.v
// Purpose: boundary-scan test access port sampled on MCLK
// Assumes: test clock far slower than MCLK
// Notes: edges of the test clock found after synchronising
`timescale 1ns/10ps
`include "tap_defs.vh"
module tap_port #(
  parameter [31:0] ID_CODE = 32'h00000001 // arbitrary value
) (
  input wire MCLK,
  input wire RSTN,
  input wire TEST_PORT_CLOCK,
  input wire TEST_PORT_RESET_N,
  input wire TEST_MODE_SELECT,
  input wire TEST_SERIAL_IN,
  input wire DIGITAL_PINS_ENABLE,
  output reg TEST_SERIAL_OUT,
  output reg TEST_SERIAL_OUT_OE,
  output reg DIGITAL_PINS_FLOAT,
  output reg TEST_MODE_ACTIVE
);
  // ----------------------------------------
  // reset and input sync
  // ----------------------------------------
  reg rst1_q;
  reg rst2_q;
  wire rst_n;
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rst1_q <= 1'b0;
      rst2_q <= 1'b0;
    end else begin
      rst1_q <= 1'b1;
      rst2_q <= rst1_q;
    end
  end
  assign rst_n = rst2_q;

  wire [`TAP_SY_BITS-1:0] sy;
  tap_sync #(.WIDTH(`TAP_SY_BITS)) u_sync (
    .clk(MCLK),
    .rst_n(rst_n),
    .d({DIGITAL_PINS_ENABLE, TEST_PORT_RESET_N, TEST_MODE_SELECT, TEST_SERIAL_IN,
        TEST_PORT_CLOCK}),
    .q(sy)
  );
  wire den_s = sy[`TAP_SY_DEN];
  wire trst_s = sy[`TAP_SY_TRST];
  wire tms_s = sy[`TAP_SY_TMS];
  wire tdi_s = sy[`TAP_SY_TDI];
  wire tck_s = sy[`TAP_SY_TCK];

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  // no edges until the sync chain and the history flops hold real pin levels,
  // so a test reset idling high never looks like a release
  reg [`TAP_WARM_BITS-1:0] warm_q;
  reg tck_q;
  reg trst_q;
  wire warm = warm_q[`TAP_WARM_BITS-1];

  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      warm_q <= {`TAP_WARM_BITS{1'b0}};
      tck_q <= 1'b0;
      trst_q <= 1'b0;
    end else begin
      warm_q <= {warm_q[`TAP_WARM_BITS-2:0], 1'b1};
      tck_q <= tck_s;
      trst_q <= trst_s;
    end
  end

  wire tck_rise = warm & tck_s & ~tck_q;
  wire tck_fall = warm & ~tck_s & tck_q;
  wire trst_rise = warm & trst_s & ~trst_q;
  wire trst_low = ~trst_s;

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  localparam ST_BITS = 16;
  localparam [ST_BITS-1:0] ST_RESET = 16'h0001;
  localparam [ST_BITS-1:0] ST_IDLE = 16'h0002;
  localparam [ST_BITS-1:0] ST_SELDR = 16'h0004;
  localparam [ST_BITS-1:0] ST_CAPDR = 16'h0008;
  localparam [ST_BITS-1:0] ST_SHDR = 16'h0010;
  localparam [ST_BITS-1:0] ST_EX1DR = 16'h0020;
  localparam [ST_BITS-1:0] ST_PSDR = 16'h0040;
  localparam [ST_BITS-1:0] ST_EX2DR = 16'h0080;
  localparam [ST_BITS-1:0] ST_UPDR = 16'h0100;
  localparam [ST_BITS-1:0] ST_SELIR = 16'h0200;
  localparam [ST_BITS-1:0] ST_CAPIR = 16'h0400;
  localparam [ST_BITS-1:0] ST_SHIR = 16'h0800;
  localparam [ST_BITS-1:0] ST_EX1IR = 16'h1000;
  localparam [ST_BITS-1:0] ST_PSIR = 16'h2000;
  localparam [ST_BITS-1:0] ST_EX2IR = 16'h4000;
  localparam [ST_BITS-1:0] ST_UPIR = 16'h8000;

  reg [ST_BITS-1:0] st_q;
  reg [ST_BITS-1:0] st_d;
  reg [`TAP_IR_BITS-1:0] ir_q;
  reg [`TAP_IR_BITS-1:0] irsh_q;
  reg [`TAP_ID_BITS-1:0] dr_q;
  reg byp_q;
  reg armed_q;

  // port steps only on a rise while released
  wire step = trst_s & armed_q & tck_rise;

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_RESET: st_d = tms_s ? ST_RESET : ST_IDLE;
      ST_IDLE: st_d = tms_s ? ST_SELDR : ST_IDLE;
      ST_SELDR: st_d = tms_s ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: st_d = tms_s ? ST_EX1DR : ST_SHDR;
      ST_SHDR: st_d = tms_s ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: st_d = tms_s ? ST_UPDR : ST_PSDR;
      ST_PSDR: st_d = tms_s ? ST_EX2DR : ST_PSDR;
      ST_EX2DR: st_d = tms_s ? ST_UPDR : ST_SHDR;
      ST_UPDR: st_d = tms_s ? ST_SELDR : ST_IDLE;
      ST_SELIR: st_d = tms_s ? ST_RESET : ST_CAPIR;
      ST_CAPIR: st_d = tms_s ? ST_EX1IR : ST_SHIR;
      ST_SHIR: st_d = tms_s ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: st_d = tms_s ? ST_UPIR : ST_PSIR;
      ST_PSIR: st_d = tms_s ? ST_EX2IR : ST_PSIR;
      ST_EX2IR: st_d = tms_s ? ST_UPIR : ST_SHIR;
      ST_UPIR: st_d = tms_s ? ST_SELDR : ST_IDLE;
      default: st_d = ST_RESET;
    endcase
  end

  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_RESET;
      armed_q <= 1'b0;
    end else if (trst_low) begin
      st_q <= ST_RESET;
      armed_q <= 1'b0;
    end else if (trst_rise) begin
      st_q <= ST_RESET;
      armed_q <= 1'b1;
    end else if (step) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // instruction path
  // ----------------------------------------
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ir_q <= `TAP_IR_BYPASS;
      irsh_q <= {`TAP_IR_BITS{1'b0}};
    end else if (trst_low) begin
      ir_q <= `TAP_IR_BYPASS;
    end else if (trst_rise) begin
      ir_q <= `TAP_IR_IDCODE;
    end else if (step) begin
      case (st_q)
        ST_RESET: ir_q <= `TAP_IR_IDCODE;
        ST_CAPIR: irsh_q <= `TAP_IR_CAPTURE;
        ST_SHIR: irsh_q <= {tdi_s, irsh_q[`TAP_IR_BITS-1:1]};
        ST_UPIR: ir_q <= irsh_q;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // data path
  // ----------------------------------------
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      dr_q <= {`TAP_ID_BITS{1'b0}};
      byp_q <= 1'b0;
    end else if (step) begin
      case (st_q)
        ST_CAPDR: begin
          dr_q <= ID_CODE;
          byp_q <= 1'b0;
        end
        ST_SHDR: begin
          dr_q <= {tdi_s, dr_q[`TAP_ID_BITS-1:1]};
          byp_q <= tdi_s;
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // serial output
  // ----------------------------------------
  wire id_sel = (ir_q == `TAP_IR_IDCODE);
  wire in_shir = (st_q == ST_SHIR);
  wire in_shdr = (st_q == ST_SHDR);
  wire dr_bit = id_sel ? dr_q[0] : byp_q;

  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      TEST_SERIAL_OUT <= 1'b0;
      TEST_SERIAL_OUT_OE <= 1'b0;
    end else if (trst_low) begin
      TEST_SERIAL_OUT_OE <= 1'b0;
    end else if (armed_q && tck_fall) begin
      // launch on fall, drive in shift only
      TEST_SERIAL_OUT_OE <= in_shir | in_shdr;
      if (in_shir) begin
        TEST_SERIAL_OUT <= irsh_q[0];
      end else if (in_shdr) begin
        TEST_SERIAL_OUT <= dr_bit;
      end
    end
  end

  // ----------------------------------------
  // pin status
  // ----------------------------------------
  always @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      DIGITAL_PINS_FLOAT <= 1'b0;
      TEST_MODE_ACTIVE <= 1'b0;
    end else begin
      DIGITAL_PINS_FLOAT <= warm & ~den_s & trst_low;
      if (trst_low) begin
        TEST_MODE_ACTIVE <= 1'b0;
      end else if (trst_rise) begin
        TEST_MODE_ACTIVE <= 1'b1;
      end
    end
  end
endmodule // tap_port

// ===== design/tap_sync.v
// Purpose: two-flop synchroniser, one per bit
// Assumes: async inputs
// Notes: first stage read only by second
`timescale 1ns/10ps
module tap_sync #(
  parameter WIDTH = 4
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule // tap_sync
